// ### design/nand_feat_pkg.sv
// shared constants and types for the serial nand status and feature register block
package nand_feat_pkg;
	// opcodes
	localparam logic [7:0] OP_WREN   = 8'h06;
	localparam logic [7:0] OP_WRDI   = 8'h04;
	localparam logic [7:0] OP_GET    = 8'h0f;
	localparam logic [7:0] OP_SET    = 8'h1f;
	localparam logic [7:0] OP_EXEC   = 8'h10;
	localparam logic [7:0] OP_READ   = 8'h13;
	localparam logic [7:0] OP_ERASE  = 8'hd8;
	localparam logic [7:0] OP_RESET  = 8'hff;
	// feature addresses
	localparam logic [7:0] FA_CONFIG = 8'hb0;
	localparam logic [7:0] FA_STATUS = 8'hc0;
	localparam logic [7:0] FA_DRIVE  = 8'hd0;
	localparam logic [7:0] FA_EXT    = 8'hf0;
	// field positions
	localparam int DS_LSB        = 5;
	localparam int CFG_PRT_BIT   = 7;
	localparam int CFG_EN_BIT    = 6;
	localparam int CFG_ECC_BIT   = 4;
	// reset values
	localparam logic [1:0] DS_RESET     = 2'h0;
	localparam logic       BPS_RESET    = 1'b1;
	localparam logic       ECC_EN_RESET = 1'b1;
	// link bit counts
	localparam logic [4:0] CNT_OPC  = 5'h07;
	localparam logic [4:0] CNT_ADDR = 5'h0f;
	localparam logic [4:0] CNT_DATA = 5'h17;
	localparam logic [4:0] CNT_RD0  = 5'h10;
	localparam logic [4:0] CNT_MAX  = 5'h1f;
	// timing of the internal reset busy period
	localparam int CLK_MHZ       = 40;
	localparam int RESET_BUSY_NS = 1000;
	localparam int RESET_BUSY_CYC = (RESET_BUSY_NS * CLK_MHZ + 999) / 1000;

	typedef enum logic [1:0] {K_PROG, K_READ, K_ERASE, K_RST} op_kind_t;

	typedef struct packed {
		logic [7:0] op;
		logic [7:0] addr;
		logic [7:0] data;
	} cmd_t;

	// register snapshot shown to the link
	typedef struct packed {
		logic [7:0] status;
		logic [7:0] drive;
		logic [7:0] ext;
		logic [7:0] config_b;
	} snap_t;
endpackage : nand_feat_pkg

// ### design/nand_feat_regs.sv
// serial-link feature command decoder with status, drive and one-time region control
`timescale 1ns/1ps
module spi_nand_status_otp_regs #(
	parameter int RST_CYC = nand_feat_pkg::RESET_BUSY_CYC
) (
	input  wire logic                      clk_sys_in,
	input  wire logic                      sys_rst_in,
	input  wire logic                      spi_clk_in,
	input  wire logic                      spi_cs_n_in,
	input  wire logic                      spi_mosi_in,
	output logic                           spi_miso_out,
	output logic                           spi_miso_oe_n_out,
	input  wire logic                      core_done_in,
	input  wire logic                      core_fail_in,
	input  wire logic [3:0]                core_ecc_bits_in,
	input  wire logic                      core_ecc_uncorr_in,
	input  wire logic                      core_block_prot_in,
	input  wire logic                      otp_nv_locked_in,
	output logic                           array_start_out,
	output nand_feat_pkg::op_kind_t        array_kind_out,
	output logic                           array_otp_out,
	output logic                           otp_burn_out,
	output logic [1:0]                     drive_strength_out,
	output logic                           ecc_enable_out
);

	// link-side state, clocked by the serial clock; the frame state is cleared while deselected, the held command only by system reset
	typedef struct packed {
		logic [4:0]           cnt;
		logic [7:0]           sh;
		logic [7:0]           opc;
		logic [7:0]           addr;
		logic [7:0]           txb;
	} link_t;
	typedef struct packed {
		nand_feat_pkg::cmd_t  cmd;
		logic                 tgl;
	} hold_t;

	// system-side state
	typedef struct packed {
		logic                    write_enable_latch;
		logic                    pfail;
		logic                    efail;
		logic                    operation_in_progress;
		logic [1:0]              ecc_primary_status;
		logic [1:0]              ecce;
		logic [1:0]              ds;
		logic                    otp_en;
		logic                    one_time_protect_bit;
		logic                    ecc_en;
		logic                    locked;
		logic                    block_protection_status;
		nand_feat_pkg::op_kind_t kind;
		logic                    otp_op;
		logic [7:0]              busy;
		logic                    start;
		logic                    burn;
		logic [2:0]              cmd_sy;
		logic [1:0]              cs_sy;
		nand_feat_pkg::snap_t    snap;
	} sys_t;

	link_t l_r;
	link_t l_nxt;
	hold_t h_r;
	hold_t h_nxt;
	sys_t  s_r;
	sys_t  s_nxt;
	logic  miso_r;
	logic  oe_n_r;
	logic [7:0]          byte_in;
	logic                ev;
	nand_feat_pkg::cmd_t ev_cmd;
	logic                prt_rd;

	// ecc outcome to {primary, extended} code
	function automatic logic [3:0] ecc_code(input logic [3:0] bits, input logic uncorr);
		logic [3:0] c;
		c = 4'h0;
		if (uncorr || bits > 4'h8)
			c = 4'h8;
		else if (bits == 4'h8)
			c = 4'hc;
		else if (bits >= 4'h5)
			c = {2'b01, bits[1:0]};
		else if (bits != 4'h0)
			c = 4'h4;
		return c;
	endfunction : ecc_code

	// feature byte picked by address; unmapped reads as zero
	function automatic logic [7:0] feat_byte(input logic [7:0] a, input nand_feat_pkg::snap_t s);
		logic [7:0] b;
		unique case (a)
			nand_feat_pkg::FA_STATUS: b = s.status;
			nand_feat_pkg::FA_EXT:    b = s.ext;
			nand_feat_pkg::FA_DRIVE:  b = s.drive;
			nand_feat_pkg::FA_CONFIG: b = s.config_b;
			default:                  b = 8'h00;
		endcase
		return b;
	endfunction : feat_byte

	assign byte_in = {l_r.sh[6:0], spi_mosi_in};

	// link decode: opcode, address and data bytes, msb first, mode 0
	always_comb begin
		l_nxt = l_r;
		h_nxt = h_r;
		l_nxt.sh = byte_in;
		if (l_r.cnt == nand_feat_pkg::CNT_DATA && l_r.opc == nand_feat_pkg::OP_GET)
			l_nxt.cnt = nand_feat_pkg::CNT_RD0; // repeated read of the same byte
		else if (l_r.cnt != nand_feat_pkg::CNT_MAX)
			l_nxt.cnt = l_r.cnt + 5'h01;
		if (l_r.cnt == nand_feat_pkg::CNT_OPC) begin
			l_nxt.opc = byte_in;
			// row address bytes of array commands belong to the array path
			if (byte_in != nand_feat_pkg::OP_GET && byte_in != nand_feat_pkg::OP_SET) begin
				h_nxt.cmd = '{op: byte_in, addr: 8'h00, data: 8'h00};
				h_nxt.tgl = ~h_r.tgl;
			end
		end
		if (l_r.cnt == nand_feat_pkg::CNT_ADDR) begin
			l_nxt.addr = byte_in;
			l_nxt.txb = feat_byte(byte_in, s_r.snap);
		end
		if (l_r.cnt == nand_feat_pkg::CNT_DATA && l_r.opc == nand_feat_pkg::OP_SET) begin
			h_nxt.cmd = '{op: l_r.opc, addr: l_r.addr, data: byte_in};
			h_nxt.tgl = ~h_r.tgl;
		end
	end

	// deselect clears the frame; the serial clock may stand still between frames
	always_ff @(posedge spi_clk_in or posedge spi_cs_n_in) begin
		if (spi_cs_n_in)
			l_r <= '0;
		else
			l_r <= l_nxt;
	end

	// held command outlives the frame so the system side can still read it; serial clock idle at reset
	always_ff @(posedge spi_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in)
			h_r <= '0;
		else
			h_r <= h_nxt;
	end

	// read data launched on the falling edge so it is stable at the next rise
	always_ff @(negedge spi_clk_in or posedge spi_cs_n_in) begin
		if (spi_cs_n_in) begin
			miso_r <= 1'b0;
			oe_n_r <= 1'b1;
		end else begin
			miso_r <= l_r.txb[~l_r.cnt[2:0]];
			oe_n_r <= !(l_r.opc == nand_feat_pkg::OP_GET && l_r.cnt >= nand_feat_pkg::CNT_RD0);
		end
	end

	// command event: held word is stable long before the synced toggle arrives
	assign ev     = s_r.cmd_sy[2] ^ s_r.cmd_sy[1];
	assign ev_cmd = h_r.cmd;
	assign prt_rd = s_r.one_time_protect_bit | s_r.locked;

	// system-side command execution and status tracking
	always_comb begin
		s_nxt = s_r;
		s_nxt.start = 1'b0;
		s_nxt.burn = 1'b0;
		s_nxt.cmd_sy = {s_r.cmd_sy[1:0], h_r.tgl};
		s_nxt.cs_sy = {s_r.cs_sy[0], spi_cs_n_in};
		s_nxt.locked = s_r.locked | otp_nv_locked_in;
		if (ev) begin
			unique case (ev_cmd.op)
				nand_feat_pkg::OP_WREN: s_nxt.write_enable_latch = 1'b1;
				nand_feat_pkg::OP_WRDI: s_nxt.write_enable_latch = 1'b0;
				nand_feat_pkg::OP_SET: begin
					// status registers c0 and f0 fall through and take no write
					if (ev_cmd.addr == nand_feat_pkg::FA_DRIVE)
						s_nxt.ds = ev_cmd.data[nand_feat_pkg::DS_LSB +: 2];
					if (ev_cmd.addr == nand_feat_pkg::FA_CONFIG) begin
						s_nxt.one_time_protect_bit = ev_cmd.data[nand_feat_pkg::CFG_PRT_BIT];
						s_nxt.otp_en = ev_cmd.data[nand_feat_pkg::CFG_EN_BIT];
						s_nxt.ecc_en = ev_cmd.data[nand_feat_pkg::CFG_ECC_BIT];
					end
				end
				nand_feat_pkg::OP_EXEC: begin
					s_nxt.pfail = 1'b0;
					if (s_r.write_enable_latch && !s_r.operation_in_progress) begin
						if (s_r.otp_en && s_r.locked) begin
							s_nxt.pfail = 1'b1;
						end else if (s_r.otp_en && s_r.one_time_protect_bit) begin
							s_nxt.burn = 1'b1;
							s_nxt.locked = 1'b1;
							s_nxt.write_enable_latch = 1'b0;
						end else if (!s_r.otp_en && core_block_prot_in) begin
							s_nxt.pfail = 1'b1;
							s_nxt.block_protection_status = 1'b1;
						end else begin
							// one-time page order is left to the host
							s_nxt.start = 1'b1;
							s_nxt.kind = nand_feat_pkg::K_PROG;
							s_nxt.otp_op = s_r.otp_en;
							s_nxt.operation_in_progress = 1'b1;
							s_nxt.block_protection_status = core_block_prot_in & !s_r.otp_en;
						end
					end
				end
				nand_feat_pkg::OP_READ: begin
					if (!s_r.operation_in_progress) begin
						s_nxt.ecc_primary_status = 2'h0;
						s_nxt.ecce = 2'h0;
						s_nxt.start = 1'b1;
						s_nxt.kind = nand_feat_pkg::K_READ;
						s_nxt.otp_op = s_r.otp_en;
						s_nxt.operation_in_progress = 1'b1;
					end
				end
				nand_feat_pkg::OP_ERASE: begin
					s_nxt.efail = 1'b0;
					if (s_r.write_enable_latch && !s_r.operation_in_progress) begin
						if (s_r.otp_en || core_block_prot_in) begin
							s_nxt.efail = 1'b1;
							s_nxt.block_protection_status = core_block_prot_in;
						end else begin
							s_nxt.start = 1'b1;
							s_nxt.kind = nand_feat_pkg::K_ERASE;
							s_nxt.otp_op = 1'b0;
							s_nxt.operation_in_progress = 1'b1;
							s_nxt.block_protection_status = 1'b0;
						end
					end
				end
				nand_feat_pkg::OP_RESET: begin
					// features, drive strength and protection survive this command
					s_nxt.pfail = 1'b0;
					s_nxt.efail = 1'b0;
					s_nxt.write_enable_latch = 1'b0;
					s_nxt.ecc_primary_status = 2'h0;
					s_nxt.ecce = 2'h0;
					s_nxt.operation_in_progress = 1'b1;
					s_nxt.kind = nand_feat_pkg::K_RST;
					s_nxt.busy = 8'(RST_CYC);
				end
				default: ;
			endcase
		end
		// array completion; a failure set here wins over any clear above
		if (core_done_in && s_r.operation_in_progress && s_r.kind != nand_feat_pkg::K_RST) begin
			s_nxt.operation_in_progress = 1'b0;
			unique case (s_r.kind)
				nand_feat_pkg::K_PROG: begin
					s_nxt.pfail = s_nxt.pfail | core_fail_in;
					s_nxt.write_enable_latch = 1'b0;
				end
				nand_feat_pkg::K_ERASE: begin
					s_nxt.efail = s_nxt.efail | core_fail_in;
					s_nxt.write_enable_latch = 1'b0;
				end
				nand_feat_pkg::K_READ: begin
					// fields stay zero, hence meaningless, with ecc disabled
					if (s_r.ecc_en)
						{s_nxt.ecc_primary_status, s_nxt.ecce} = ecc_code(core_ecc_bits_in, core_ecc_uncorr_in);
				end
				default: ;
			endcase
		end
		// reset command busy period
		if (s_r.kind == nand_feat_pkg::K_RST && s_r.operation_in_progress && !ev) begin
			s_nxt.busy = s_r.busy - 8'h01;
			if (s_r.busy <= 8'h01)
				s_nxt.operation_in_progress = 1'b0;
		end
		// refresh only while deselected; a frame reads it frozen, so select must lead address end by 2 cycles
		if (s_r.cs_sy[1]) begin
			s_nxt.snap.status = {2'b00, s_r.ecc_primary_status, s_r.pfail, s_r.efail, s_r.write_enable_latch, s_r.operation_in_progress};
			s_nxt.snap.drive = {1'b0, s_r.ds, 5'h00};
			s_nxt.snap.ext = {2'b00, s_r.ecce, s_r.block_protection_status, 3'h0};
			s_nxt.snap.config_b = {prt_rd, s_r.otp_en, 1'b0, s_r.ecc_en, 4'h0};
		end
	end

	// power-on reset; the nv lock level is folded in after release
	always_ff @(posedge clk_sys_in) begin
		if (sys_rst_in) begin
			s_r <= '0;
			s_r.ds <= nand_feat_pkg::DS_RESET;
			s_r.block_protection_status <= nand_feat_pkg::BPS_RESET;
			s_r.ecc_en <= nand_feat_pkg::ECC_EN_RESET;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign spi_miso_out       = miso_r;
	assign spi_miso_oe_n_out  = oe_n_r;
	assign array_start_out    = s_r.start;
	assign array_kind_out     = s_r.kind;
	assign array_otp_out      = s_r.otp_op;
	assign otp_burn_out       = s_r.burn;
	assign drive_strength_out = s_r.ds;
	assign ecc_enable_out     = s_r.ecc_en;

	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (sys_rst_in);

	property p_wel_set;
		ev && ev_cmd.op == nand_feat_pkg::OP_WREN |=> s_r.write_enable_latch;
	endproperty
	a_wel_set: assert property (p_wel_set) else $error("latch not set by write enable");

	property p_wel_clr;
		ev && ev_cmd.op == nand_feat_pkg::OP_WRDI && !core_done_in |=> !s_r.write_enable_latch;
	endproperty
	a_wel_clr: assert property (p_wel_clr) else $error("latch not cleared by write disable");

	property p_otp_prog_refused;
		ev && ev_cmd.op == nand_feat_pkg::OP_EXEC && s_r.write_enable_latch && !s_r.operation_in_progress && s_r.otp_en && s_r.locked
			|=> s_r.pfail && !array_start_out;
	endproperty
	a_otp_prog_refused: assert property (p_otp_prog_refused) else $error("locked region programmed");

	property p_otp_erase_refused;
		ev && ev_cmd.op == nand_feat_pkg::OP_ERASE && s_r.write_enable_latch && !s_r.operation_in_progress && s_r.otp_en
			|=> s_r.efail && !s_r.operation_in_progress;
	endproperty
	a_otp_erase_refused: assert property (p_otp_erase_refused) else $error("one-time erase not refused");

	property p_read_start;
		ev && ev_cmd.op == nand_feat_pkg::OP_READ && !s_r.operation_in_progress
			|=> s_r.operation_in_progress && s_r.ecc_primary_status == 2'h0 && s_r.ecce == 2'h0 && array_start_out;
	endproperty
	a_read_start: assert property (p_read_start) else $error("read start wrong");

	property p_ecc_eight;
		core_done_in && s_r.operation_in_progress && s_r.kind == nand_feat_pkg::K_READ && s_r.ecc_en
			&& core_ecc_bits_in == 4'h8 && !core_ecc_uncorr_in |=> s_r.ecc_primary_status == 2'h3;
	endproperty
	a_ecc_eight: assert property (p_ecc_eight) else $error("eight-bit ecc code wrong");

	property p_ecc_five;
		core_done_in && s_r.operation_in_progress && s_r.kind == nand_feat_pkg::K_READ && s_r.ecc_en
			&& core_ecc_bits_in == 4'h5 && !core_ecc_uncorr_in |=> s_r.ecc_primary_status == 2'h1 && s_r.ecce == 2'h1;
	endproperty
	a_ecc_five: assert property (p_ecc_five) else $error("five-bit ecc code wrong");

	property p_wel_auto;
		core_done_in && s_r.operation_in_progress && (s_r.kind == nand_feat_pkg::K_PROG || s_r.kind == nand_feat_pkg::K_ERASE)
			&& !ev |=> !s_r.write_enable_latch;
	endproperty
	a_wel_auto: assert property (p_wel_auto) else $error("latch kept after operation");

	property p_reset_busy;
		ev && ev_cmd.op == nand_feat_pkg::OP_RESET |=> s_r.operation_in_progress [*8];
	endproperty
	a_reset_busy: assert property (p_reset_busy) else $error("reset busy too short");

	property p_lock_sticky;
		s_r.locked |=> s_r.locked && prt_rd;
	endproperty
	a_lock_sticky: assert property (p_lock_sticky) else $error("protect bit dropped");

	property p_drive_write;
		ev && ev_cmd.op == nand_feat_pkg::OP_SET && ev_cmd.addr == nand_feat_pkg::FA_DRIVE
			|=> drive_strength_out == $past(ev_cmd.data[6:5]);
	endproperty
	a_drive_write: assert property (p_drive_write) else $error("drive strength not written");

endmodule : spi_nand_status_otp_regs

// ### dv/spi_host_model.sv
// host-side serial controller model issuing feature command frames
`timescale 1ns/1ps
module spi_host_model (
	output logic      spi_clk_out,
	output logic      spi_cs_n_out,
	output logic      spi_mosi_out,
	input  wire logic spi_miso_in,
	input  wire logic spi_miso_oe_n_in
);
	// serial clock parked low outside frames
	initial begin
		spi_clk_out = 1'b0;
		spi_cs_n_out = 1'b1;
		spi_mosi_out = 1'b0;
	end

	// factory bad-block scan: any marker other than the erased ff retires the block
	function automatic logic block_usable(input logic [7:0] mark);
		return mark == 8'hff;
	endfunction : block_usable

	// mode 0 frame, msb first, 6 ns period; read byte taken from the third byte slot
	task automatic xfer(input logic [23:0] bits, input int n, output logic [7:0] rx);
		rx = 8'h00;
		#1.3;
		spi_cs_n_out = 1'b0;
		for (int i = 0; i < n; i++) begin
			spi_mosi_out = bits[23 - i];
			#3;
			spi_clk_out = 1'b1;
			// an undriven data line must never pass for a value
			if (i >= 16) rx = {rx[6:0], spi_miso_oe_n_in ? 1'bx : spi_miso_in};
			#3;
			spi_clk_out = 1'b0;
		end
		#3;
		spi_cs_n_out = 1'b1;
		spi_mosi_out = ~spi_mosi_out; // released line does not hold its last bit
	endtask : xfer
endmodule : spi_host_model

// ### dv/spi_nand_status_otp_regs_tb_top.sv
// self-checking bench for the status, drive and one-time region register block
`timescale 1ns/1ps
module spi_nand_status_otp_regs_tb_top;
	localparam int RST_CYC = 8; // shortened reset busy period
	logic                    clk_sys_in = 1'b0;
	logic                    sys_rst_in = 1'b1;
	logic                    sclk, cs_n, mosi, miso, miso_oe_n;
	logic                    done_p = 1'b0;
	logic                    fail_l = 1'b0;
	logic                    unc_l = 1'b0;
	logic                    prot_l = 1'b0;
	logic                    nv_lock = 1'b0;
	logic [3:0]              bits_l = 4'h0;
	logic                    start, otp, burn, ecc_en;
	logic [1:0]              ds;
	nand_feat_pkg::op_kind_t kind;
	logic [7:0]              rd;
	int                      fails = 0;
	int                      checked = 0;
	int                      starts = 0;
	int                      burns = 0;
	int                      s0, b0;

	spi_nand_status_otp_regs #(.RST_CYC(RST_CYC)) dut (.clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in),
		.spi_clk_in(sclk), .spi_cs_n_in(cs_n), .spi_mosi_in(mosi), .spi_miso_out(miso),
		.spi_miso_oe_n_out(miso_oe_n), .core_done_in(done_p), .core_fail_in(fail_l),
		.core_ecc_bits_in(bits_l), .core_ecc_uncorr_in(unc_l), .core_block_prot_in(prot_l),
		.otp_nv_locked_in(nv_lock), .array_start_out(start), .array_kind_out(kind), .array_otp_out(otp),
		.otp_burn_out(burn), .drive_strength_out(ds), .ecc_enable_out(ecc_en));

	spi_host_model host (.spi_clk_out(sclk), .spi_cs_n_out(cs_n), .spi_mosi_out(mosi), .spi_miso_in(miso),
		.spi_miso_oe_n_in(miso_oe_n));

	// 40 MHz system clock
	initial begin
		forever #12.5 clk_sys_in = ~clk_sys_in;
	end

	// count one-cycle pulses; they stand a single cycle so each edge is looked at
	always @(posedge clk_sys_in) begin
		if (start === 1'b1) starts++;
		if (burn === 1'b1) burns++;
	end

	task automatic results;
		if (fails == 0 && checked > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : results

	task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
		checked++;
		if (seen !== exp) begin
			fails++;
			$display("unexpected %s: expected %h, seen %h", what, exp, seen);
		end
	endtask : chk

	// one frame, then idle past the 150 ns command spacing and the sync delay
	task automatic frame(input logic [23:0] b, input int n);
		host.xfer(b, n, rd);
		repeat (8) @(negedge clk_sys_in);
	endtask : frame

	task automatic cmd(input logic [7:0] op);
		frame({op, 16'h0000}, 8);
	endtask : cmd

	task automatic setf(input logic [7:0] a, input logic [7:0] d);
		frame({nand_feat_pkg::OP_SET, a, d}, 24);
	endtask : setf

	task automatic getf(input logic [7:0] a, input logic [7:0] m, input logic [7:0] exp, input string what);
		frame({nand_feat_pkg::OP_GET, a, 8'h00}, 24);
		chk(rd & m, exp, what);
	endtask : getf

	// completion pulse from the array core with its result qualifiers
	task automatic fin(input logic f, input logic [3:0] nb, input logic u);
		fail_l = f;
		bits_l = nb;
		unc_l = u;
		done_p = 1'b1;
		@(negedge clk_sys_in);
		done_p = 1'b0;
		repeat (4) @(negedge clk_sys_in);
	endtask : fin

	// ecc table: corrected count, uncorrectable flag, primary code, extended code
	logic [3:0] e_n [8] = '{4'h0, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9, 4'h3};
	logic       e_u [8] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1};
	logic [1:0] e_p [8] = '{2'h0, 2'h1, 2'h1, 2'h1, 2'h1, 2'h3, 2'h2, 2'h2};
	logic [1:0] e_e [8] = '{2'h0, 2'h0, 2'h1, 2'h2, 2'h3, 2'h0, 2'h0, 2'h0};

	initial begin
		repeat (10) @(negedge clk_sys_in);
		sys_rst_in = 1'b0;
		repeat (6) @(negedge clk_sys_in);
		getf(8'hc0, 8'hff, 8'h00, "status after reset");
		getf(8'hf0, 8'hff, 8'h08, "ext after reset");
		getf(8'hb0, 8'hff, 8'h10, "config after reset");
		chk({6'h00, ds}, 8'h00, "drive pins after reset");
		for (int i = 0; i < 4; i++) begin
			setf(8'hd0, {1'b0, 2'(i), 5'h00});
			getf(8'hd0, 8'hff, {1'b0, 2'(i), 5'h00}, "drive readback");
			chk({6'h00, ds}, 8'(i), "drive pins");
		end
		setf(8'hd0, 8'h40);
		setf(8'hc0, 8'hff);
		setf(8'hf0, 8'hff);
		getf(8'hc0, 8'hff, 8'h00, "status after write");
		getf(8'hf0, 8'hff, 8'h08, "ext after write");
		cmd(nand_feat_pkg::OP_WREN);
		getf(8'hc0, 8'hff, 8'h02, "latch set");
		cmd(nand_feat_pkg::OP_WRDI);
		s0 = starts;
		cmd(nand_feat_pkg::OP_EXEC);
		chk(8'(starts - s0), 8'h00, "exec without latch");
		getf(8'hc0, 8'hff, 8'h00, "latch cleared");
		chk({7'h00, host.block_usable(8'hff)}, 8'h01, "erased marker");
		chk({7'h00, host.block_usable(8'h00)}, 8'h00, "bad-block marker");
		// program that fails, then one that passes; the second start clears the failure
		for (int k = 0; k < 2; k++) begin
			cmd(nand_feat_pkg::OP_WREN);
			s0 = starts;
			cmd(nand_feat_pkg::OP_EXEC);
			chk(8'(starts - s0), 8'h01, "program start");
			chk({5'h00, kind, otp}, {5'h00, nand_feat_pkg::K_PROG, 1'b0}, "program kind");
			getf(8'hc0, 8'hff, 8'h03, "program busy");
			getf(8'hf0, 8'hff, 8'h00, "unprotected block");
			fin(k == 0, 4'h0, 1'b0);
			getf(8'hc0, 8'hff, k == 0 ? 8'h08 : 8'h00, "program result");
		end
		for (int k = 0; k < 2; k++) begin
			cmd(nand_feat_pkg::OP_WREN);
			s0 = starts;
			cmd(nand_feat_pkg::OP_ERASE);
			chk({6'(starts - s0), kind}, {6'h01, nand_feat_pkg::K_ERASE}, "erase start");
			getf(8'hc0, 8'hff, 8'h03, "erase busy");
			fin(k == 0, 4'h0, 1'b0);
			getf(8'hc0, 8'hff, k == 0 ? 8'h04 : 8'h00, "erase result");
		end
		for (int k = 0; k < 8; k++) begin
			cmd(nand_feat_pkg::OP_READ);
			chk({6'h00, kind}, {6'h00, nand_feat_pkg::K_READ}, "read kind");
			getf(8'hc0, 8'hff, 8'h01, "read busy");
			fin(1'b0, e_n[k], e_u[k]);
			getf(8'hc0, 8'hff, {2'b00, e_p[k], 4'h0}, "ecc primary");
			getf(8'hf0, e_p[k] == 2'h1 ? 8'h30 : 8'h00, {2'b00, e_e[k], 4'h0}, "ecc extended");
		end
		// protected target refused, then a reset command clears the error flags
		prot_l = 1'b1;
		cmd(nand_feat_pkg::OP_WREN);
		s0 = starts;
		cmd(nand_feat_pkg::OP_EXEC);
		chk(8'(starts - s0), 8'h00, "protected start");
		getf(8'hc0, 8'hfd, 8'h28, "protected program");
		getf(8'hf0, 8'h08, 8'h08, "protected block");
		prot_l = 1'b0;
		cmd(nand_feat_pkg::OP_RESET);
		repeat (RST_CYC) @(negedge clk_sys_in);
		getf(8'hc0, 8'hff, 8'h00, "status after reset command");
		getf(8'hf0, 8'hff, 8'h08, "ext after reset command");
		getf(8'hd0, 8'hff, 8'h40, "drive after reset command");
		setf(8'hb0, 8'h00);
		chk({7'h00, ecc_en}, 8'h00, "ecc off");
		cmd(nand_feat_pkg::OP_READ);
		fin(1'b0, 4'h5, 1'b0);
		getf(8'hc0, 8'hff, 8'h00, "ecc off status");
		// one-time region: access, lock, then refusals
		setf(8'hb0, 8'h50);
		cmd(nand_feat_pkg::OP_WREN);
		s0 = starts;
		cmd(nand_feat_pkg::OP_EXEC);
		chk({6'(starts - s0), 1'b0, otp}, 8'h05, "one-time program");
		fin(1'b0, 4'h0, 1'b0);
		cmd(nand_feat_pkg::OP_READ);
		chk({5'h00, kind, otp}, {5'h00, nand_feat_pkg::K_READ, 1'b1}, "one-time read");
		fin(1'b0, 4'h0, 1'b0);
		setf(8'hb0, 8'hd0);
		cmd(nand_feat_pkg::OP_WREN);
		s0 = starts;
		b0 = burns;
		cmd(nand_feat_pkg::OP_EXEC);
		chk({4'(starts - s0), 4'(burns - b0)}, 8'h01, "lock burn");
		setf(8'hb0, 8'h50);
		getf(8'hb0, 8'hd0, 8'hd0, "protect kept");
		cmd(nand_feat_pkg::OP_WREN);
		s0 = starts;
		cmd(nand_feat_pkg::OP_EXEC);
		cmd(nand_feat_pkg::OP_WREN);
		cmd(nand_feat_pkg::OP_ERASE);
		chk(8'(starts - s0), 8'h00, "locked region starts");
		getf(8'hc0, 8'hfd, 8'h0c, "locked region refused");
		// power-on with the region already locked in nv storage
		nv_lock = 1'b1;
		sys_rst_in = 1'b1;
		repeat (2) @(negedge clk_sys_in);
		sys_rst_in = 1'b0;
		repeat (6) @(negedge clk_sys_in);
		getf(8'hb0, 8'hff, 8'h90, "nv protect");
		chk({6'h00, ds}, 8'h00, "drive after power-on");
		results();
	end

	// watchdog well beyond the roughly 1300 cycles the sequence needs
	initial begin
		repeat (30000) @(posedge clk_sys_in);
		fails++;
		results();
	end
endmodule : spi_nand_status_otp_regs_tb_top
